// ---- urs_pkg.sv ----
// package: register map, field positions and reset values for the uart receive status block
package urs_pkg;
  // apb byte addresses
  localparam logic [7:0] URS_STA_OFF = 8'h00;
  localparam logic [7:0] URS_DATA_OFF = 8'h04;
  localparam logic [7:0] URS_CFG_OFF = 8'h08;
  localparam logic [7:0] URS_IST_OFF = 8'h0C;
  localparam logic [7:0] URS_IMSK_OFF = 8'h10;
  // status register field positions
  localparam int URS_ADDRESS_DETECT_ENABLE_BIT = 5;
  localparam int URS_IDLE_BIT = 4;
  localparam int URS_PARITY_ERROR_FLAG_BIT = 3;
  localparam int URS_FRAMING_ERROR_FLAG_BIT = 2;
  localparam int URS_OVERRUN_ERROR_FLAG_BIT = 1;
  localparam int URS_AVAIL_BIT = 0;
  // data register: bit 8 is the ninth data bit
  localparam int URS_NINTH_BIT = 8;
  // config register fields
  localparam int URS_CFG_NINE_BIT = 0;
  localparam int URS_CFG_PAR_BIT = 1;
  localparam int URS_CFG_PODD_BIT = 2;
  // interrupt status bits
  localparam int URS_EV_RX = 0;
  localparam int URS_EV_OVR = 1;
  localparam int URS_EV_ERR = 2;
  localparam int URS_NEV = 3;
  // defaults
  localparam int URS_DEF_DIV = 868;
  localparam int URS_DEF_DEPTH = 4;
  localparam logic [15:0] URS_DIV_RST = 16'h0364;
  // receiver states
  typedef enum logic [3:0] {
    URS_IDLE = 4'b0001,
    URS_START = 4'b0010,
    URS_DATA = 4'b0100,
    URS_STOP = 4'b1000
  } urs_state_t;
endpackage

// ---- urs_fifo.sv ----
// receive fifo holding data plus per-character error bits
`timescale 1ns/1ps
module urs_fifo import urs_pkg::*; #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic flush,
  // write side
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  // read side
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);
  // elaboration check: pointer wrap logic needs a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_chk
    $error("depth must be a power of two, at least 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;
  wire full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  wire empty = (wp_r == rp_r);
  wire do_wr = wr_valid && !full;
  wire do_rd = rd_ready && !empty;
  assign wr_ready = !full;
  assign rd_valid = !empty;
  assign rd_data = mem[rp_r[AW-1:0]];
  // pointers; flush empties the buffer outright
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_r <= '0;
      rp_r <= '0;
    end else if (flush) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (do_wr) wp_r <= wp_r + 1'b1;
      if (do_rd) rp_r <= rp_r + 1'b1;
    end
  end
  // storage
  always_ff @(posedge pclk) begin
    if (do_wr) mem[wp_r[AW-1:0]] <= wr_data;
  end
endmodule

// ---- urs_top.sv ----
// uart receiver with status register, address detect and error reporting
//
// Functional notes
// - address-detect enable bit 5 turns address detect mode on or off.
// - in address mode only ninth-bit-one words are kept; needs nine-bit mode.
// - read-only idle flag at bit 4 is one while receiver idle.
// - read-only parity error flag bit 3 reflects character at fifo head.
// - read-only framing error flag bit 2 reflects character at fifo head.
// - overrun flag bit 1 set by hardware on overflow; software can only clear.
// - clearing a set overrun flag empties fifo and shift register.
// - data-available flag bit 0 is one while fifo holds a character.
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module urs_top import urs_pkg::*; #(
  parameter int DEPTH = URS_DEF_DEPTH
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial line
  input wire logic rx_line,
  // interrupt
  output logic irq
);
  localparam int FW = 11;
  // elaboration check: the fifo and its pointers need at least two entries
  if (DEPTH < 2) begin : g_depth_chk
    $error("depth must be at least 2");
  end
  ////////////////////////////////////////////////////////////////
  // bus decode
  wire acc = psel && penable;
  wire wr_en = acc && pwrite;
  wire rd_en = acc && !pwrite;
  wire hit_sta = paddr == URS_STA_OFF;
  wire hit_dat = paddr == URS_DATA_OFF;
  wire hit_cfg = paddr == URS_CFG_OFF;
  wire hit_ist = paddr == URS_IST_OFF;
  wire hit_msk = paddr == URS_IMSK_OFF;
  wire mapped = hit_sta | hit_dat | hit_cfg | hit_ist | hit_msk;
  ////////////////////////////////////////////////////////////////
  // registers
  logic addr_en_r;
  logic overrun_error_flag_r;
  logic [2:0] cfg_r;
  logic [15:0] div_r;
  logic [URS_NEV-1:0] ist_r;
  logic [URS_NEV-1:0] imsk_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic irq_r;
  // receiver
  urs_state_t st_r;
  logic [15:0] cnt_r;
  logic [3:0] bit_r;
  logic [8:0] sh_r;
  logic par_r;
  logic push_r;
  logic [FW-1:0] push_d_r;
  logic busy_r;
  // fifo wires
  logic f_wr_ready;
  logic f_rd_valid;
  logic [FW-1:0] f_rd_data;
  ////////////////////////////////////////////////////////////////
  // overrun clear detection: software writes zero over a set flag
  wire overrun_error_flag_clr = wr_en && hit_sta && !pwdata[URS_OVERRUN_ERROR_FLAG_BIT] && overrun_error_flag_r;
  wire flush = overrun_error_flag_clr;
  wire pop = rd_en && hit_dat && f_rd_valid;
  wire overflow = push_r && !f_wr_ready;
  urs_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .flush(flush),
    .wr_valid(push_r),
    .wr_ready(f_wr_ready),
    .wr_data(push_d_r),
    .rd_valid(f_rd_valid),
    .rd_ready(pop),
    .rd_data(f_rd_data)
  );
  ////////////////////////////////////////////////////////////////
  // status read word; error bits come from the fifo head entry
  wire [31:0] sta_word = {26'h0, addr_en_r, !busy_r,
    f_rd_valid & f_rd_data[10], f_rd_valid & f_rd_data[9],
    overrun_error_flag_r, f_rd_valid};
  wire [31:0] rd_mux = hit_sta ? sta_word :
                       hit_dat ? {23'h0, f_rd_data[8:0]} :
                       hit_cfg ? {13'h0, div_r, cfg_r} :
                       hit_ist ? {29'h0, ist_r} :
                       hit_msk ? {29'h0, imsk_r} : 32'h0;
  // zero-wait slave: pready always high, unmapped address errors
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r <= (psel && !penable && !pwrite) ? rd_mux : prdata_r;
      pslverr_r <= psel && !penable && !mapped;
    end
  end
  ////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_en_r <= 1'b0;
      cfg_r <= 3'h0;
      div_r <= URS_DIV_RST;
      imsk_r <= '0;
    end else if (wr_en) begin
      if (hit_sta) addr_en_r <= pwdata[URS_ADDRESS_DETECT_ENABLE_BIT];
      if (hit_cfg) begin
        cfg_r <= pwdata[2:0];
        div_r <= pwdata[18:3];
      end
      if (hit_msk) imsk_r <= pwdata[URS_NEV-1:0];
    end
  end
  // overrun flag: hardware set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) overrun_error_flag_r <= 1'b0;
    else if (overflow) overrun_error_flag_r <= 1'b1;
    else if (overrun_error_flag_clr) overrun_error_flag_r <= 1'b0;
  end
  // sticky interrupt status, write one to clear, set wins
  wire [URS_NEV-1:0] ev = {push_d_r[10] | push_d_r[9], overflow, push_r & f_wr_ready} & {URS_NEV{push_r}};
  wire [URS_NEV-1:0] w1c = (wr_en && hit_ist) ? pwdata[URS_NEV-1:0] : '0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_r <= '0;
      irq_r <= 1'b0;
    end else begin
      ist_r <= (ist_r & ~w1c) | ev;
      irq_r <= |(((ist_r & ~w1c) | ev) & imsk_r);
    end
  end
  ////////////////////////////////////////////////////////////////
  // receiver: 16-bit divider gives bit time, sample mid-bit
  wire nine = cfg_r[URS_CFG_NINE_BIT];
  wire par_en = cfg_r[URS_CFG_PAR_BIT];
  wire [3:0] nbits = nine ? 4'd9 : 4'd8;
  wire tick = (cnt_r == 16'h0);
  wire [15:0] half = {1'b0, div_r[15:1]};
  wire [8:0] word = nine ? sh_r : {1'b0, sh_r[8:1]};
  // address mode gates non-address words only in nine-bit mode
  wire keep = !(addr_en_r && nine) || word[URS_NINTH_BIT];
  wire par_bad = par_en && (par_r ^ cfg_r[URS_CFG_PODD_BIT] ^ rx_line) ;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= URS_IDLE;
      cnt_r <= 16'h0;
      bit_r <= 4'h0;
      sh_r <= 9'h0;
      par_r <= 1'b0;
      busy_r <= 1'b0;
      push_r <= 1'b0;
      push_d_r <= '0;
    end else if (flush) begin
      st_r <= URS_IDLE;
      sh_r <= 9'h0;
      busy_r <= 1'b0;
      push_r <= 1'b0;
      cnt_r <= 16'h0;
    end else begin
      push_r <= 1'b0;
      cnt_r <= tick ? 16'h0 : cnt_r - 16'h1;
      unique case (st_r)
        URS_IDLE: begin
          busy_r <= 1'b0;
          if (!rx_line) begin
            st_r <= URS_START;
            cnt_r <= half;
            busy_r <= 1'b1;
          end
        end
        URS_START: if (tick) begin
          if (rx_line) st_r <= URS_IDLE;
          else begin
            st_r <= URS_DATA;
            cnt_r <= div_r;
            bit_r <= 4'h0;
            par_r <= 1'b0;
          end
        end
        URS_DATA: if (tick) begin
          cnt_r <= div_r;
          if (bit_r == nbits) begin
            st_r <= URS_STOP;
            par_r <= par_bad;
          end else begin
            sh_r <= {rx_line, sh_r[8:1]};
            par_r <= par_r ^ rx_line;
            bit_r <= bit_r + 4'h1;
            if (!par_en && bit_r + 4'h1 == nbits) st_r <= URS_STOP;
          end
        end
        URS_STOP: if (tick) begin
          st_r <= URS_IDLE;
          busy_r <= 1'b0;
          push_r <= keep;
          push_d_r <= {par_en & par_r, !rx_line, word};
        end
        default: st_r <= URS_IDLE;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////
  // checks
  overrun_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    overflow |=> overrun_error_flag_r) else $error("overrun not flagged");
  overrun_flush_a: assert property (@(posedge pclk) disable iff (!presetn)
    (overrun_error_flag_clr && !overflow) |=> !f_rd_valid && st_r == URS_IDLE) else $error("clear did not flush");
  avail_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    sta_word[URS_AVAIL_BIT] == f_rd_valid) else $error("avail flag wrong");
  idle_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r == URS_DATA) |-> !sta_word[URS_IDLE_BIT]) else $error("idle while receiving");
  parity_error_flag_head_a: assert property (@(posedge pclk) disable iff (!presetn)
    !f_rd_valid |-> !sta_word[URS_PARITY_ERROR_FLAG_BIT]) else $error("parity flag without data");
  framing_error_flag_head_a: assert property (@(posedge pclk) disable iff (!presetn)
    !f_rd_valid |-> !sta_word[URS_FRAMING_ERROR_FLAG_BIT]) else $error("framing flag without data");
  addr_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r == URS_STOP && tick && addr_en_r && nine && !word[8] && !flush) |=> !push_r)
    else $error("data word kept in address mode");
  address_detect_enable_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit_sta) |=> addr_en_r == $past(pwdata[URS_ADDRESS_DETECT_ENABLE_BIT])) else $error("enable not stored");
  ////////////////////////////////////////////////////////////////
  // helper logic for the checks: fifo occupancy and bit ticks per frame
  localparam int OW = $clog2(DEPTH) + 1;
  logic [OW-1:0] occ_r;
  logic [3:0] tk_cnt_r;
  wire [OW-1:0] occ_full = OW'(DEPTH);
  wire in_ok = push_r && f_wr_ready;
  // occupancy mirrors the fifo from its handshakes, not from its pointers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) occ_r <= '0;
    else if (flush) occ_r <= '0;
    else if (in_ok && !pop) occ_r <= occ_r + 1'b1;
    else if (pop && !in_ok) occ_r <= occ_r - 1'b1;
  end
  // ticks since the start edge; saturates so a hang cannot wrap back to legal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tk_cnt_r <= 4'h0;
    else if (st_r == URS_IDLE) tk_cnt_r <= 4'h0;
    else if (tick && tk_cnt_r != 4'hF) tk_cnt_r <= tk_cnt_r + 4'h1;
  end
  ////////////////////////////////////////////////////////////////
  // named steps shared by the checks below
  sequence s_kept_end;
    st_r == URS_STOP && tick && !flush && keep;
  endsequence
  sequence s_plain_end;
    st_r == URS_STOP && tick && !flush && !addr_en_r;
  endsequence
  sequence s_eight_end;
    st_r == URS_STOP && tick && !flush && !nine;
  endsequence
  sequence s_head_load;
    push_r && f_wr_ready && !f_rd_valid && !flush;
  endsequence
  sequence s_rd_setup;
    psel && !penable && !pwrite;
  endsequence
  sequence s_bus_access;
    psel && penable;
  endsequence
  sequence s_line_rest;
    st_r == URS_IDLE && rx_line;
  endsequence
  // a kept character reaches the fifo one cycle after its stop sample
  char_push_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_kept_end |=> push_r) else $error("kept character not pushed");
  // with address detect off every character is kept
  address_detect_enable_off_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_plain_end |=> push_r) else $error("character lost with detect off");
  // eight-bit frames ignore address detect
  eight_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_eight_end |=> push_r) else $error("eight-bit character lost");
  // a push happens only on the way back to idle
  push_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    push_r |-> st_r == URS_IDLE) else $error("push outside frame end");
  // software can never raise the overrun flag
  overrun_error_flag_no_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!overrun_error_flag_r && !overflow) |=> !overrun_error_flag_r) else $error("overrun set without overflow");
  // the overrun flag holds until software clears it
  overrun_error_flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (overrun_error_flag_r && !overrun_error_flag_clr) |=> overrun_error_flag_r) else $error("overrun flag lost");
  // the flush empties the shift register as well
  shift_flush_a: assert property (@(posedge pclk) disable iff (!presetn)
    overrun_error_flag_clr |=> sh_r == 9'h000 && !busy_r) else $error("shift register not flushed");
  // a character loaded into an empty fifo shows its own error bits at once
  parity_error_flag_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_head_load |=> sta_word[URS_PARITY_ERROR_FLAG_BIT] == $past(push_d_r[10])) else $error("parity flag not from head");
  framing_error_flag_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_head_load |=> sta_word[URS_FRAMING_ERROR_FLAG_BIT] == $past(push_d_r[9])) else $error("framing flag not from head");
  // receiver shows busy from the start bit on
  start_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == URS_START |-> !sta_word[URS_IDLE_BIT]) else $error("idle during start bit");
  // a resting line leaves the receiver idle
  rest_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_line_rest |=> sta_word[URS_IDLE_BIT]) else $error("busy on resting line");
  // no frame lasts longer than start, nine data, parity and stop ticks
  frame_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    tk_cnt_r <= 4'hC) else $error("receiver stuck busy");
  // read data is taken in setup and stands through access
  rd_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_rd_setup ##1 s_bus_access |-> prdata_r == $past(rd_mux)) else $error("read data not held");
  // unmapped addresses answer with an error in the access phase
  slverr_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !mapped) |=> pslverr_r) else $error("no error for unmapped address");
  // overflow fires only when the fifo holds depth characters
  ovr_full_a: assert property (@(posedge pclk) disable iff (!presetn)
    overflow |-> occ_r == occ_full) else $error("overflow while not full");
  // a character meeting a full fifo is dropped, the stored ones stay
  drop_full_a: assert property (@(posedge pclk) disable iff (!presetn)
    (overflow && !pop && !flush) |=> occ_r == occ_full) else $error("full fifo changed on overflow");
  // data available exactly while something is held
  avail_count_a: assert property (@(posedge pclk) disable iff (!presetn)
    sta_word[URS_AVAIL_BIT] == (occ_r != '0)) else $error("avail flag disagrees with contents");
  // reading the last character empties the buffer
  last_pop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pop && !in_ok && !flush && occ_r == 1) |=> !f_rd_valid) else $error("buffer not empty after last read");
  // overflow events latch in the interrupt status, set wins over clear
  ovr_event_a: assert property (@(posedge pclk) disable iff (!presetn)
    overflow |=> ist_r[URS_EV_OVR]) else $error("overflow event lost");
  // write one clears a received-character event when no new one comes
  ist_w1c_a: assert property (@(posedge pclk) disable iff (!presetn)
    (w1c[URS_EV_RX] && !ev[URS_EV_RX]) |=> !ist_r[URS_EV_RX]) else $error("event not cleared");
  // an unmasked event raises the interrupt line
  irq_raise_a: assert property (@(posedge pclk) disable iff (!presetn)
    (|(ev & imsk_r)) |=> irq_r) else $error("interrupt not raised");
  // nothing pending and unmasked keeps the line low
  irq_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ev == '0 && (ist_r & imsk_r) == '0) |=> !irq_r) else $error("interrupt without cause");
endmodule

// ---- urs_tx_model.sv ----
// behavioural serial transmitter that drives the receive line
`timescale 1ns/1ps
module urs_tx_model #(
  parameter int BIT_CYC = 64
) (
  // clock
  input wire logic pclk,
  // serial line
  output logic rx_line
);
  // line rests high between frames
  initial rx_line = 1'b1;
  // one bit cell, changed just after a rising edge
  task automatic put(input logic b);
    @(posedge pclk) rx_line <= b;
    repeat (BIT_CYC - 1) @(posedge pclk);
  endtask
  // start, data lsb first, optional parity, stop; odd flips the parity sense
  task automatic send(input logic [8:0] d, input int nb, input logic par, input logic odd, input logic bad_stop);
    logic p;
    p = odd;
    put(1'b0);
    for (int i = 0; i < nb; i++) begin
      put(d[i]);
      p = p ^ d[i];
    end
    if (par) begin
      put(p);
    end
    put(~bad_stop);
    // a broken stop still returns the line to idle
    @(posedge pclk) rx_line <= 1'b1;
  endtask
endmodule

// ---- tb.sv ----
// self-checking bench for the uart receive status block
`timescale 1ns/1ps
module tb import urs_pkg::*; ;
  localparam int BITC = 64;
  // divider one below the bit time, so either counting reading samples mid-bit
  localparam logic [31:0] CFG = 32'(BITC - 1) << 3;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_line, irq, re;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rq;
  int err_count = 0;
  int comparisons = 0;
  urs_top #(.DEPTH(4)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_line(rx_line), .irq(irq));
  urs_tx_model #(.BIT_CYC(BITC)) tx_u (.pclk(pclk), .rx_line(rx_line));
  ////////////////////////////////////////////////////////////////
  // verdict and comparison helpers
  task automatic test_done();
    if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      chk("pready", 1, 0);
      test_done();
    end
  endtask
  task automatic wait_char();
    repeat (8) @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    apb(0, URS_STA_OFF, 0);
    chk("idle", 1, rq[URS_IDLE_BIT]);
    chk("avail", 0, rq[URS_AVAIL_BIT]);
    chk("overrun_error_flag", 0, rq[URS_OVERRUN_ERROR_FLAG_BIT]);
    apb(0, 8'h20, 0);
    chk("unmapped err", 1, re);
    chk("unmapped data", 0, rq);
  endtask
  task automatic t_rx();
    apb(1, URS_CFG_OFF, CFG);
    apb(1, URS_IMSK_OFF, 32'h1);
    fork
      tx_u.send(9'h0A5, 8, 0, 0, 0);
      begin
        repeat (BITC * 3) @(posedge pclk);
        apb(0, URS_STA_OFF, 0);
        chk("busy idle", 0, rq[URS_IDLE_BIT]);
      end
    join
    wait_char();
    apb(0, URS_STA_OFF, 0);
    chk("avail", 1, rq[URS_AVAIL_BIT]);
    chk("irq", 1, irq);
    apb(0, URS_DATA_OFF, 0);
    chk("data", 9'h0A5, rq[8:0]);
    apb(0, URS_STA_OFF, 0);
    chk("drained", 0, rq[URS_AVAIL_BIT]);
    apb(1, URS_IST_OFF, 32'h1);
    apb(1, URS_IMSK_OFF, 32'h0);
    chk("irq clear", 0, irq);
  endtask
  task automatic t_err();
    apb(1, URS_CFG_OFF, CFG | 32'h2);
    tx_u.send(9'h03C, 8, 1, 1, 0);
    tx_u.send(9'h03C, 8, 1, 0, 0);
    tx_u.send(9'h00F, 8, 1, 0, 1);
    wait_char();
    apb(0, URS_STA_OFF, 0);
    chk("parity_error_flag head", 1, rq[URS_PARITY_ERROR_FLAG_BIT]);
    chk("framing_error_flag clean", 0, rq[URS_FRAMING_ERROR_FLAG_BIT]);
    apb(0, URS_DATA_OFF, 0);
    apb(0, URS_STA_OFF, 0);
    chk("parity_error_flag next", 0, rq[URS_PARITY_ERROR_FLAG_BIT]);
    apb(0, URS_DATA_OFF, 0);
    apb(0, URS_STA_OFF, 0);
    chk("framing_error_flag head", 1, rq[URS_FRAMING_ERROR_FLAG_BIT]);
    chk("parity_error_flag third", 0, rq[URS_PARITY_ERROR_FLAG_BIT]);
    apb(0, URS_DATA_OFF, 0);
    apb(1, URS_IST_OFF, 32'h7);
  endtask
  task automatic t_ovr();
    apb(1, URS_CFG_OFF, CFG);
    for (int i = 1; i <= 5; i++) tx_u.send(9'(i), 8, 0, 0, 0);
    wait_char();
    apb(0, URS_STA_OFF, 0);
    chk("overrun_error_flag set", 1, rq[URS_OVERRUN_ERROR_FLAG_BIT]);
    apb(0, URS_IST_OFF, 0);
    chk("ovr event", 1, rq[URS_EV_OVR]);
    apb(1, URS_STA_OFF, 32'h2);
    apb(0, URS_STA_OFF, 0);
    chk("overrun_error_flag held", 1, rq[URS_OVERRUN_ERROR_FLAG_BIT]);
    apb(0, URS_DATA_OFF, 0);
    chk("oldest kept", 9'h001, rq[8:0]);
    apb(1, URS_STA_OFF, 32'h0);
    apb(0, URS_STA_OFF, 0);
    chk("overrun_error_flag clear", 0, rq[URS_OVERRUN_ERROR_FLAG_BIT]);
    chk("flushed", 0, rq[URS_AVAIL_BIT]);
    apb(1, URS_STA_OFF, 32'h2);
    apb(0, URS_STA_OFF, 0);
    chk("overrun_error_flag no set", 0, rq[URS_OVERRUN_ERROR_FLAG_BIT]);
    apb(1, URS_IST_OFF, 32'h7);
  endtask
  task automatic t_addr();
    apb(1, URS_CFG_OFF, CFG | 32'h1);
    apb(1, URS_STA_OFF, 32'h20);
    tx_u.send(9'h012, 9, 0, 0, 0);
    wait_char();
    apb(0, URS_STA_OFF, 0);
    chk("address_detect_enable", 1, rq[URS_ADDRESS_DETECT_ENABLE_BIT]);
    chk("data word skipped", 0, rq[URS_AVAIL_BIT]);
    tx_u.send(9'h1A3, 9, 0, 0, 0);
    wait_char();
    apb(0, URS_DATA_OFF, 0);
    chk("address word", 9'h1A3, rq[8:0]);
    apb(1, URS_STA_OFF, 32'h0);
    tx_u.send(9'h012, 9, 0, 0, 0);
    wait_char();
    apb(0, URS_DATA_OFF, 0);
    chk("mode off", 9'h012, rq[8:0]);
    apb(1, URS_CFG_OFF, CFG);
    apb(1, URS_STA_OFF, 32'h20);
    tx_u.send(9'h034, 8, 0, 0, 0);
    wait_char();
    apb(0, URS_DATA_OFF, 0);
    chk("eight bit ignores", 9'h034, rq[8:0]);
  endtask
  ////////////////////////////////////////////////////////////////
  // clock, reset and main sequence
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_rx();
    t_err();
    t_ovr();
    t_addr();
    test_done();
  end
endmodule
